// [cof_pkg.sv]
// Types of the close-onto-fault timer
package cof_pkg;
    typedef enum logic [1:0] {
        COF_FORCE_NORMAL,
        COF_FORCE_BLOCKED,
        COF_FORCE_ACTIVE,
        COF_FORCE_TRIP
    } cof_force_t;
    typedef enum logic [2:0] {
        COF_COND_NORMAL,
        COF_COND_INIT,
        COF_COND_ACTIVE,
        COF_COND_TRIP,
        COF_COND_BLOCKED
    } cof_cond_t;
    // Event bit order: init, block, active, trip
    typedef logic [3:0] cof_evt_t;
endpackage

// [cof_regs.svh]
// Register offsets, fields and timing counts of the close-onto-fault timer
`ifndef COF_REGS_SVH
`define COF_REGS_SVH
`define COF_CTRL_OFS 12'h000
`define COF_RELEASE_OFS 12'h004
`define COF_STATUS_OFS 12'h008
`define COF_IRQ_STAT_OFS 12'h00C
`define COF_IRQ_EN_OFS 12'h010
`define COF_IRQ_CLR_OFS 12'h014
`define COF_CNT_INIT_OFS 12'h018
`define COF_CNT_BLOCK_OFS 12'h01C
`define COF_CNT_ACTIVE_OFS 12'h020
`define COF_CNT_TRIP_OFS 12'h024
`define COF_LOG_PTR_OFS 12'h028
`define COF_TIME_OFS 12'h02C
`define COF_LOG_BASE_OFS 12'h100
`define COF_CTRL_FORCE_EN_BIT 0
`define COF_CTRL_FORCE_LSB 1
`define COF_CTRL_SG_LSB 4
`define COF_CTRL_ONSEL_LSB 8
`define COF_CTRL_OFFSEL_LSB 12
`define COF_CTRL_CNT_CLR_BIT 16
`define COF_CTRL_RST 32'h0000_FF00
`define COF_RELEASE_RST 32'h0000_03E8
`define COF_CLK_HZ 40000000
`define COF_MS_PER_S 1000
`define COF_MS_CYCLES (`COF_CLK_HZ / `COF_MS_PER_S)
`endif

// [cof_relay_model.sv]
// Relay logic model driving activate, block and start inputs
`timescale 1ns/1ps
module cof_relay_model (
    // Relay signals
    output logic activate,
    output logic block_in,
    output logic [7:0] start_in
);
    initial begin
        activate = 1'b0;
        block_in = 1'b0;
        start_in = 8'h00;
    end
    // Called just after an edge; binary levels only
    task set(input logic a, b, input logic [7:0] s);
        activate <= a;
        block_in <= b;
        start_in <= s;
    endtask
endmodule // cof_relay_model

// [cof_timer.sv]
// Close-onto-fault arming timer with APB registers and event log
// Functional notes
// - A rising edge on activate arms the block; a held level does not.
// - While the window runs and the block input is inactive, an active function input trips at once.
// - Tripping adds no delay once armed and any start signal is active.
// - An active block input prevents the window from starting.
// - Window length is set in milliseconds and defaults to one second.
// - A new window length may be written while running and is used later.
// - Forced status blocked/active/trip applies only when enabled; forced normal shows the live condition.
// - A readable condition shows normal, init, active, trip or blocked.
// - Init, block, active and trip raise ON and OFF events, selectable.
// - Clearable counters count init, blocked, active and trip events.
// - Each active ON event is logged in a twelve-entry circular log.
// - Log records hold time, event, group, remaining and elapsed time.
// - Only binary inputs are used; no analog measurement.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "cof_regs.svh"
module cof_timer #(
    parameter int LOG_DEPTH = 12,
    parameter int MS_CYCLES = `COF_MS_CYCLES
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Relay logic, binary states only
    input wire logic activate,
    input wire logic block_in,
    input wire logic [7:0] start_in,
    output logic trip,
    output logic armed,
    output logic blocked,
    output cof_pkg::cof_cond_t condition,
    // Interrupt
    output logic irq
);
    import cof_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_q;
    logic [31:0] release_q;
    logic [3:0] irq_stat_q, irq_en_q;
    logic [31:0] cnt_q [4];
    logic [31:0] ms_time_q;
    logic [$clog2(MS_CYCLES)-1:0] pre_q;
    logic ms_tick;
    logic act_q;
    logic [31:0] remain_q, elapsed_q;
    logic trip_q;
    cof_cond_t cond_q;
    cof_evt_t lvl, lvl_q, ev_on, ev_off;
    logic [31:0] log_time [LOG_DEPTH];
    logic [31:0] log_info [LOG_DEPTH];
    logic [31:0] log_rem [LOG_DEPTH];
    logic [31:0] log_act [LOG_DEPTH];
    logic [3:0] log_wp_q;
    logic [4:0] log_cnt_q;
    logic wr_en, rd_en, hit;
    logic func_in, edge_act, force_en, start_ok;
    cof_force_t force_v;
    logic [31:0] rd_d;
    // Identity code of the active event in a log record
    localparam logic [3:0] LOG_CODE_ACT = 4'h4;

    function automatic logic [3:0] wrap_inc(input logic [3:0] p);
        return (p == 4'(LOG_DEPTH - 1)) ? 4'h0 : p + 4'h1;
    endfunction

    // Register write strobe for one offset
    function automatic logic wr_at(input logic [11:0] ofs);
        return wr_en && (paddr == ofs);
    endfunction

    // One word of a log record, selected by address bits 3:2
    function automatic logic [31:0] log_word(input logic [3:0] idx,
        input logic [1:0] sel);
        case (sel)
            2'h0: return log_time[idx];
            2'h1: return log_info[idx];
            2'h2: return log_rem[idx];
            default: return log_act[idx];
        endcase
    endfunction

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign func_in = |start_in;
    assign edge_act = activate && !act_q;
    assign force_en = ctrl_q[`COF_CTRL_FORCE_EN_BIT];
    assign force_v = cof_force_t'(ctrl_q[`COF_CTRL_FORCE_LSB +: 2]);
    assign start_ok = edge_act && !block_in;
    ////////////////////////////////////////////////////////////////////////
    // Millisecond timebase, also the event time stamp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
        end else if (ms_tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end
    // Free-running, so time stamps wrap after about seven weeks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_time_q <= 32'h0;
        end else if (ms_tick) begin
            ms_time_q <= ms_time_q + 32'h1;
        end
    end
    assign ms_tick = (pre_q == $bits(pre_q)'(MS_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q <= 1'b0;
        end else begin
            act_q <= activate;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Release window; length sampled at each start so a new value only
    // affects later windows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain_q <= 32'h0;
        end else if (start_ok) begin
            remain_q <= release_q;
        end else if (ms_tick && armed) begin
            remain_q <= remain_q - 32'h1;
        end
    end
    // Elapsed time stops with the window and is kept until the next start clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            elapsed_q <= 32'h0;
        end else if (start_ok) begin
            elapsed_q <= 32'h0;
        end else if (ms_tick && armed) begin
            elapsed_q <= elapsed_q + 32'h1;
        end
    end
    assign armed = (remain_q != 32'h0);

    // Trip is combinational on the armed state so it costs no cycle
    always_comb begin
        trip_q = armed && func_in;
        cond_q = COF_COND_NORMAL;
        if (block_in) begin
            cond_q = COF_COND_BLOCKED;
        end else if (trip_q) begin
            cond_q = COF_COND_TRIP;
        end else if (start_ok) begin
            cond_q = COF_COND_INIT;
        end else if (armed) begin
            cond_q = COF_COND_ACTIVE;
        end
        if (force_en) begin
            case (force_v)
                COF_FORCE_BLOCKED: cond_q = COF_COND_BLOCKED;
                COF_FORCE_ACTIVE: cond_q = COF_COND_ACTIVE;
                COF_FORCE_TRIP: cond_q = COF_COND_TRIP;
                default: ;
            endcase
        end
    end
    assign condition = cond_q;
    assign trip = (cond_q == COF_COND_TRIP);
    assign blocked = (cond_q == COF_COND_BLOCKED);
    ////////////////////////////////////////////////////////////////////////
    // Events
    assign lvl = {trip, cond_q == COF_COND_ACTIVE, blocked,
                  cond_q == COF_COND_INIT};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q <= 4'h0;
        end else begin
            lvl_q <= lvl;
        end
    end
    assign ev_on = lvl & ~lvl_q;
    assign ev_off = ~lvl & lvl_q;

    // Set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 4'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_at(`COF_IRQ_CLR_OFS) ?
                pwdata[3:0] : 4'h0))
                | (ev_on & ctrl_q[`COF_CTRL_ONSEL_LSB +: 4])
                | (ev_off & ctrl_q[`COF_CTRL_OFFSEL_LSB +: 4]);
        end
    end
    assign irq = |(irq_stat_q & irq_en_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) cnt_q[i] <= 32'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_at(`COF_CTRL_OFS) &&
                    pwdata[`COF_CTRL_CNT_CLR_BIT]) begin
                    cnt_q[i] <= ev_on[i] ? 32'h1 : 32'h0;
                end else if (ev_on[i]) begin
                    cnt_q[i] <= cnt_q[i] + 32'h1;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Circular log of active ON events
    always_ff @(posedge pclk) begin
        if (ev_on[2]) begin
            log_time[log_wp_q] <= ms_time_q;
            log_info[log_wp_q] <= {24'h0, 1'b0,
                ctrl_q[`COF_CTRL_SG_LSB +: 3], LOG_CODE_ACT};
            log_rem[log_wp_q] <= remain_q;
            log_act[log_wp_q] <= elapsed_q;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_wp_q <= 4'h0;
        end else if (ev_on[2]) begin
            log_wp_q <= wrap_inc(log_wp_q);
        end
    end
    // Entry count saturates once the oldest record starts to be lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_cnt_q <= 5'h0;
        end else if (ev_on[2] && log_cnt_q != 5'(LOG_DEPTH)) begin
            log_cnt_q <= log_cnt_q + 5'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Register writes, one block per register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `COF_CTRL_RST;
        end else if (wr_at(`COF_CTRL_OFS)) begin
            ctrl_q <= {16'h0, pwdata[15:0]};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            release_q <= `COF_RELEASE_RST;
        end else if (wr_at(`COF_RELEASE_OFS)) begin
            release_q <= pwdata;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= 4'h0;
        end else if (wr_at(`COF_IRQ_EN_OFS)) begin
            irq_en_q <= pwdata[3:0];
        end
    end

    always_comb begin
        hit = 1'b1;
        rd_d = 32'h0;
        case (paddr)
            `COF_CTRL_OFS: rd_d = ctrl_q;
            `COF_RELEASE_OFS: rd_d = release_q;
            `COF_STATUS_OFS: rd_d = {23'h0, armed, trip, blocked, 1'b0,
                                     2'b00, 3'(cond_q)};
            `COF_IRQ_STAT_OFS: rd_d = {28'h0, irq_stat_q};
            `COF_IRQ_EN_OFS: rd_d = {28'h0, irq_en_q};
            `COF_IRQ_CLR_OFS: rd_d = 32'h0;
            `COF_CNT_INIT_OFS: rd_d = cnt_q[0];
            `COF_CNT_BLOCK_OFS: rd_d = cnt_q[1];
            `COF_CNT_ACTIVE_OFS: rd_d = cnt_q[2];
            `COF_CNT_TRIP_OFS: rd_d = cnt_q[3];
            `COF_LOG_PTR_OFS: rd_d = {19'h0, log_cnt_q, 4'h0, log_wp_q};
            `COF_TIME_OFS: rd_d = ms_time_q;
            default: begin
                hit = 1'b0;
                if (paddr >= `COF_LOG_BASE_OFS && paddr[11:8] == 4'h1
                    && paddr[7:4] < 4'(LOG_DEPTH)) begin
                    hit = 1'b1;
                    rd_d = log_word(paddr[7:4], paddr[3:2]);
                end
            end
        endcase
    end

    // Read data captured in setup so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= rd_d;
        end
    end
    assign pslverr = psel && penable && !hit;
endmodule // cof_timer

// [cof_timer_chk.sv]
// Port checker of the close-onto-fault timer
`timescale 1ns/1ps
module cof_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Relay side
    input wire logic activate,
    input wire logic block_in,
    input wire logic [7:0] start_in,
    input wire logic trip,
    input wire logic armed,
    input wire logic blocked,
    input wire cof_pkg::cof_cond_t condition
);
    import cof_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [5:0] n_q;
    ////////////////////////////////////////////////////////////////////
    // Armed run length; any new edge restarts it, the window only when block_in is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) n_q <= 6'h00;
        else if (armed && !(activate && !$past(activate))) n_q <= n_q + 6'h01;
        else n_q <= 6'h00;
    end
    ////////////////////////////////////////////////////////////////////
    AST_ARM:
        assert property (activate && !$past(activate) && !block_in |=> armed)
        else $error("edge did not arm");
    AST_HOLD:
        assert property (!armed && !(activate && !$past(activate))
            |=> !armed) else $error("armed without edge");
    AST_BLOCK:
        assert property (block_in && !armed |=> !armed)
        else $error("armed while blocked");
    AST_TRIP:
        assert property (armed && (|start_in) && !block_in && !blocked
            |-> trip) else $error("no instant trip");
    AST_TRIPEND:
        assert property ($fell(armed) |-> !trip)
        else $error("trip past window");
    // Window of 3 ms at 4 cycles a tick, plus tick phase
    AST_WIN:
        assert property (n_q <= 6'h11) else $error("window too long");
    AST_INIT:
        assert property (activate && !$past(activate) && !block_in
            && !(|start_in) |-> condition == COF_COND_INIT)
        else $error("init not shown");
    AST_BLKD:
        assert property (block_in |-> blocked) else $error("not blocked");
endmodule // cof_chk
bind cof_timer cof_chk u_chk (.pclk, .presetn, .activate, .block_in,
    .start_in, .trip, .armed, .blocked, .condition);

// [test_close_onto_fault_arming_timer.sv]
// Register-level tests of the close-onto-fault timer
`timescale 1ns/1ps
`include "cof_regs.svh"
module test_close_onto_fault_arming_timer;
    import cof_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic trip, armed, blocked, irq, activate, block_in, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] start_in;
    cof_cond_t condition;
    int fails = 0, compares = 0, n, p0;
    cof_timer #(.MS_CYCLES(4)) DUT (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .activate,
        .block_in, .start_in, .trip, .armed, .blocked, .condition, .irq);
    cof_relay_model m (.activate, .block_in, .start_in);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task wt(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task chk(input string s, input logic [31:0] v, input logic [31:0] e);
        compares++;
        if (v !== e) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", s, e, v);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        wt(1);
        penable <= 1'b1;
        k = 0;
        do begin wt(1); k++; end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        wt(1);
    endtask
    task rdc(input string s, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(s, rd, e);
    endtask
    // Raise activate from low and count armed cycles, sampled mid-cycle
    task arm(output int c);
        m.set(1'b0, 1'b0, 8'h00);
        wt(1);
        m.set(1'b1, 1'b0, 8'h00);
        wt(2);
        c = 0;
        do begin @(negedge pclk); c++; end while (armed === 1'b1 && c < 60);
        if (c >= 60) fails++;
        wt(1);
    endtask
    task end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #250000;
        fails++;
        end_of_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        wt(3);
        presetn <= 1'b1;
        wt(1);
        rdc("ctrl", `COF_CTRL_OFS, 32'h0000_FF00);
        rdc("release", `COF_RELEASE_OFS, `COF_RELEASE_RST);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        $display("test reset done");
        apb(1'b1, `COF_RELEASE_OFS, 32'h3);
        m.set(1'b1, 1'b0, 8'h00);
        wt(1);
        m.set(1'b1, 1'b0, 8'h10);
        @(negedge pclk);
        chk("trip", {31'h0, trip}, 32'h1);
        wt(1);
        m.set(1'b1, 1'b0, 8'h00);
        @(negedge pclk);
        chk("trip off", {31'h0, trip}, 32'h0);
        wt(24);
        chk("held level", {31'h0, armed}, 32'h0);
        arm(n);
        chk("window", {31'h0, n >= 9 && n <= 12}, 32'h1);
        m.set(1'b0, 1'b0, 8'h00);
        wt(1);
        m.set(1'b1, 1'b0, 8'h00);
        wt(4);
        arm(n);
        chk("restart", {31'h0, n >= 9 && n <= 12}, 32'h1);
        $display("test arm done");
        m.set(1'b0, 1'b1, 8'h00);
        wt(1);
        m.set(1'b1, 1'b1, 8'h00);
        wt(20);
        chk("blk arm", {31'h0, armed}, 32'h0);
        rdc("blk cond", `COF_STATUS_OFS, 32'h0000_0044);
        m.set(1'b0, 1'b0, 8'h00);
        rdc("cnt init", `COF_CNT_INIT_OFS, 32'h4);
        rdc("cnt blk", `COF_CNT_BLOCK_OFS, 32'h1);
        rdc("cnt trip", `COF_CNT_TRIP_OFS, 32'h1);
        apb(1'b1, `COF_CTRL_OFS, 32'h0001_FF00);
        rdc("cnt clr", `COF_CNT_TRIP_OFS, 32'h0);
        rdc("istat", `COF_IRQ_STAT_OFS, 32'hF);
        apb(1'b1, `COF_IRQ_EN_OFS, 32'hF);
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b1, `COF_IRQ_EN_OFS, 32'h0);
        chk("irq mask", {31'h0, irq}, 32'h0);
        apb(1'b1, `COF_IRQ_EN_OFS, 32'hF);
        apb(1'b1, `COF_IRQ_CLR_OFS, 32'hF);
        chk("irq clr", {31'h0, irq}, 32'h0);
        apb(1'b1, `COF_CTRL_OFS, 32'h0000_2000);
        m.set(1'b0, 1'b1, 8'h00);
        wt(2);
        rdc("off sel on", `COF_IRQ_STAT_OFS, 32'h0);
        m.set(1'b0, 1'b0, 8'h00);
        wt(2);
        rdc("off sel off", `COF_IRQ_STAT_OFS, 32'h2);
        apb(1'b1, `COF_IRQ_CLR_OFS, 32'hF);
        $display("test block irq done");
        apb(1'b1, `COF_CTRL_OFS, 32'h0000_FF50);
        apb(1'b0, `COF_LOG_PTR_OFS, 32'h0);
        p0 = int'(rd[3:0]);
        m.set(1'b1, 1'b0, 8'h00);
        wt(3);
        apb(1'b1, `COF_RELEASE_OFS, 32'h1);
        wt(20);
        arm(n);
        chk("new len", {31'h0, n <= 4}, 32'h1);
        repeat (12) arm(n);
        apb(1'b0, `COF_LOG_PTR_OFS, 32'h0);
        chk("log ptr", rd & 32'h1F0F, 32'h0C00 | 32'((p0 + 14) % 12));
        apb(1'b0, 12'(`COF_LOG_BASE_OFS + 16 * ((p0 + 13) % 12) + 4), 0);
        chk("log group", rd & 32'h70, 32'h50);
        apb(1'b0, 12'(`COF_LOG_BASE_OFS + 16 * ((p0 + 13) % 12) + 8), 0);
        chk("log rem", rd, 32'h1);
        apb(1'b0, 12'(`COF_LOG_BASE_OFS + 16 * ((p0 + 13) % 12) + 12), 0);
        chk("log act", rd, 32'h0);
        $display("test log done");
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, `COF_CTRL_OFS, 32'h0000_FF01 | 32'(f << 1));
            apb(1'b0, `COF_STATUS_OFS, 32'h0);
            chk("force", rd & 32'h7, 32'((f == 1) ? 4 : f));
        end
        apb(1'b1, `COF_CTRL_OFS, 32'h0000_FF00);
        $display("test force done");
        end_of_test();
    end
endmodule // test_close_onto_fault_arming_timer
